// ==== src/pss_sram.sv ====
// pipelined synchronous burst sram: strobes, burst counter, data path
module pss_sram (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic [pss_pkg::ADDR_W-1:0] addr,
  input  wire logic                       processor_address_strobe_n,
  input  wire logic                       controller_address_strobe_n,
  input  wire logic                       primary_chip_select_n,
  input  wire logic                       high_chip_select,
  input  wire logic                       third_chip_select_n,
  input  wire logic                       burst_advance_n,
  input  wire logic                       all_lanes_write_n,
  input  wire logic                       byte_write_gate_n,
  input  wire logic [pss_pkg::LANES-1:0]  lane_write_select_n,
  input  wire logic                       output_drive_enable_n,
  input  wire logic                       sleep_request,
  input  wire logic                       burst_order_strap,
  input  wire logic [pss_pkg::DATA_W-1:0] dq_i,
  output      logic [pss_pkg::DATA_W-1:0] dq_o,
  output      logic [pss_pkg::DATA_W-1:0] dq_oe,
  input  wire logic [pss_pkg::LANES-1:0]  parity_byte_lines_i,
  output      logic [pss_pkg::LANES-1:0]  parity_byte_lines_o,
  output      logic [pss_pkg::LANES-1:0]  parity_byte_lines_oe
);
  import pss_pkg::*;

  // ==========================================================================
  // pin synchronisers for the two pins that are not bus timed
  logic [1:0] sleep_sync;   // sleep pin, stage 0 then stage 1
  logic [1:0] strap_sync;   // burst order strap, stage 0 then stage 1
  logic       asleep;       // synchronised sleep level
  logic       interleave;   // burst order strap level, synchronised every edge

  // two flops each; only stage 1 is looked at
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sync <= 2'h0;
      strap_sync <= 2'h3;
    end else begin
      sleep_sync <= {sleep_sync[0], sleep_request};
      strap_sync <= {strap_sync[0], burst_order_strap};
    end
  end

  // sleep low is normal; an open pin is pulled low outside the core
  assign asleep     = sleep_sync[1];
  // the strap is static, so its level is simply sampled every edge
  assign interleave = strap_sync[1];

  // ==========================================================================
  // sampled request decode
  logic                 selected;  // all three chip selects active
  logic                 accept_p;  // processor strobe taken
  logic                 accept_c;  // controller strobe taken
  logic                 wr_any;    // some lane asked to write
  logic [LANES-1:0]     lanes;     // lanes to write this edge

  always_comb begin
    selected = !primary_chip_select_n && high_chip_select
               && !third_chip_select_n;
    // primary select high hides the processor strobe
    accept_p = !processor_address_strobe_n && !primary_chip_select_n
               && !asleep;
    // the processor strobe shadows the controller strobe
    accept_c = !controller_address_strobe_n && !accept_p
               && !asleep;
    // global write beats byte gate and lane selects
    if (!all_lanes_write_n) begin
      lanes = {LANES{1'b1}};
    end else if (!byte_write_gate_n) begin
      lanes = ~lane_write_select_n;
    end else begin
      lanes = {LANES{1'b0}};
    end
    wr_any = |lanes;
  end

  // ==========================================================================
  // burst address forming
  function automatic logic [BURST_W-1:0] burst_pos(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] step,
    input logic               ilv
  );
    // interleaved xors the step, linear adds it and wraps at four
    burst_pos = ilv ? (start ^ step) : BURST_W'(start + step);
  endfunction

  // ==========================================================================
  // control state
  logic                  active;         // a burst is open
  logic [ADDR_W-1:0]     base;           // captured start address
  logic [BURST_W-1:0]    cnt;            // burst step counter
  logic                  first_clk;      // first clock out of deselect
  pss_op_type            op;             // operation of this cycle
  logic [ADDR_W-1:0]     xfer_addr;      // word address of this cycle
  logic [LANES-1:0]      wr_lanes;       // registered lane enables
  logic [LANES*LANE_W-1:0] data_reg;     // registered input word
  logic                  rd_valid;       // read word on the output reg

  logic                  next_active;
  logic [ADDR_W-1:0]     next_base;
  logic [BURST_W-1:0]    next_cnt;
  logic                  next_first_clk;
  pss_op_type            next_op;
  logic [ADDR_W-1:0]     next_xfer_addr;
  logic [LANES-1:0]      next_wr_lanes;
  logic [LANES*LANE_W-1:0] next_data_reg;
  logic                  next_rd_valid;

  // next state of the strobe, burst and data input logic
  always_comb begin
    next_active    = active;
    next_base      = base;
    next_cnt       = cnt;
    next_first_clk = 1'b0;
    next_op        = OP_IDLE;
    next_wr_lanes  = lanes;
    if (asleep) begin
      // sleep closes the burst; the array itself is left untouched
      next_active = 1'b0;
    end else if (accept_p || accept_c) begin
      if (selected) begin
        next_active    = 1'b1;
        next_base      = addr;
        next_cnt       = BURST_RST;
        next_first_clk = !active;
        // a processor strobe always opens with a read
        next_op        = (accept_c && wr_any) ? OP_WRITE : OP_READ;
      end else begin
        // strobe with a chip select off deselects the device
        next_active = 1'b0;
      end
    end else if (active) begin
      if (!burst_advance_n) begin
        next_cnt = BURST_W'(cnt + 1'b1);
      end
      next_op = wr_any ? OP_WRITE : OP_READ;
    end
    // low two bits walk the burst, the rest stay as captured
    next_xfer_addr = {next_base[ADDR_W-1:BURST_W],
                      burst_pos(next_base[BURST_W-1:0], next_cnt,
                                interleave)};
    // every lane takes its parity bit above its data byte
    for (int i = 0; i < LANES; i++) begin
      next_data_reg[i*LANE_W +: LANE_W] =
        {parity_byte_lines_i[i], dq_i[i*LANE_DATA_W +: LANE_DATA_W]};
    end
    // read issued this edge is in the output register one edge later
    next_rd_valid = (op == OP_READ);
  end

  // register the control state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active    <= 1'b0;
      base      <= ADDR_RST;
      cnt       <= BURST_RST;
      first_clk <= 1'b0;
      op        <= OP_IDLE;
      xfer_addr <= ADDR_RST;
      wr_lanes  <= {LANES{1'b0}};
      data_reg  <= '0;
      rd_valid  <= 1'b0;
    end else begin
      active    <= next_active;
      base      <= next_base;
      cnt       <= next_cnt;
      first_clk <= next_first_clk;
      op        <= next_op;
      xfer_addr <= next_xfer_addr;
      wr_lanes  <= next_wr_lanes;
      data_reg  <= next_data_reg;
      rd_valid  <= next_rd_valid;
    end
  end

  // ==========================================================================
  // storage array
  pss_mem_if #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) mif ();

  // writes land one cycle after their edge, with the registered data
  assign mif.wr_en    = (op == OP_WRITE);
  assign mif.wr_addr  = xfer_addr;
  assign mif.wr_data  = data_reg;
  assign mif.wr_lanes = wr_lanes;
  // reads sample the array at the next edge into its output register
  assign mif.rd_en    = (op == OP_READ);
  assign mif.rd_addr  = xfer_addr;

  pss_mem u_mem (
    .mclk (mclk),
    .mif  (mif)
  );

  // ==========================================================================
  // output drive
  logic drive;  // data and parity lines act as outputs

  // the enable pin acts without the clock; the mask hides the first
  // clock after deselect so the bus is not driven with stale data
  assign drive = !output_drive_enable_n && rd_valid && !first_clk
                 && !asleep;

  // unpack the registered read word onto data and parity lines
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      dq_o[i*LANE_DATA_W +: LANE_DATA_W] =
        mif.rd_data[i*LANE_W +: LANE_DATA_W];
      parity_byte_lines_o[i] = mif.rd_data[i*LANE_W + LANE_DATA_W];
    end
  end

  assign dq_oe                = {DATA_W{drive}};
  assign parity_byte_lines_oe = {LANES{drive}};

endmodule // pss_sram

// ==== src/pss_pkg.sv ====
// shared constants and types of the pipelined burst sram core
package pss_pkg;

  // ==========================================================================
  // geometry
  localparam int ADDR_W      = 18;  // word address width (256k words)
  localparam int LANES       = 4;   // byte lanes per word
  localparam int LANE_DATA_W = 8;   // data bits per lane
  localparam int LANE_W      = 9;   // lane width in the array: data + parity
  localparam int DATA_W      = 32;  // data lines
  localparam int BURST_W     = 2;   // width of the burst counter

  // ==========================================================================
  // reset values
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;  // burst counter start
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 18'h00000;

  // ==========================================================================
  // operation carried by the pipeline stage after each edge
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } pss_op_type;

endpackage : pss_pkg

// ==== src/pss_mem_if.sv ====
// carrier between the control core and the storage array
interface pss_mem_if #(
  parameter int ADDR_W = 18,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
);
  logic                    wr_en;    // write one word this cycle
  logic [ADDR_W-1:0]       wr_addr;  // write word address
  logic [LANES*LANE_W-1:0] wr_data;  // write word, lane i at [i*LANE_W+:]
  logic [LANES-1:0]        wr_lanes; // per lane write enable
  logic                    rd_en;    // read one word this cycle
  logic [ADDR_W-1:0]       rd_addr;  // read word address
  logic [LANES*LANE_W-1:0] rd_data;  // registered read word

  modport ctrl (output wr_en, wr_addr, wr_data, wr_lanes, rd_en, rd_addr,
                input rd_data);
  modport store (input wr_en, wr_addr, wr_data, wr_lanes, rd_en, rd_addr,
                 output rd_data);
endinterface : pss_mem_if

// ==== src/pss_mem.sv ====
// storage array with per lane writes and a registered read port
module pss_mem (
  input wire logic  mclk,  // core clock
  pss_mem_if.store  mif    // access from the control core
);
  import pss_pkg::*;

  // ==========================================================================
  // array
  // no reset on the array: contents survive sleep and any core reset
  logic [LANE_W-1:0] mem [LANES][2**ADDR_W];
  logic [LANES*LANE_W-1:0] rd_q;  // read data register

  // per lane write and read; one lane is one 9 bit column
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge mclk) begin
      // lane write, gated by its own enable
      if (mif.wr_en && mif.wr_lanes[i]) begin
        mem[i][mif.wr_addr] <= mif.wr_data[i*LANE_W +: LANE_W];
      end
      // read data held when no read is issued
      if (mif.rd_en) begin
        rd_q[i*LANE_W +: LANE_W] <= mem[i][mif.rd_addr];
      end
    end
  end

  assign mif.rd_data = rd_q;

endmodule // pss_mem

// ==== tb/pss_host.sv ====
// host side of the data lines: works out the level of every wire
module pss_host (
  input  wire logic        mclk,
  input  wire logic [35:0] dev_d,
  input  wire logic [35:0] dev_oe,
  input  wire logic [35:0] host_d,
  input  wire logic        host_en,
  output      logic [35:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // line resolution
  // no pull on these wires: a floating bit shows the inverse of its last
  // level, so a stale value can never pass as good data
  logic [35:0] last = '0;
  always_comb begin
    for (int i = 0; i < 36; i++) begin
      line[i] = dev_oe[i] ? dev_d[i] : host_en ? host_d[i] : ~last[i];
    end
  end
  always @(posedge mclk) last <= line;
endmodule // pss_host

// ==== tb/pss_sram_chk.sv ====
// pin level assertions of the burst sram core
module pss_sram_chk (
  input wire logic                       mclk,
  input wire logic                       rst_n,
  input wire logic [pss_pkg::ADDR_W-1:0] addr,
  input wire logic                       processor_address_strobe_n,
  input wire logic                       controller_address_strobe_n,
  input wire logic                       primary_chip_select_n,
  input wire logic                       high_chip_select,
  input wire logic                       third_chip_select_n,
  input wire logic                       all_lanes_write_n,
  input wire logic                       output_drive_enable_n,
  input wire logic                       sleep_request,
  input wire logic [pss_pkg::DATA_W-1:0] dq_i,
  input wire logic [pss_pkg::DATA_W-1:0] dq_o,
  input wire logic [pss_pkg::DATA_W-1:0] dq_oe,
  input wire logic [pss_pkg::LANES-1:0]  parity_byte_lines_i,
  input wire logic [pss_pkg::LANES-1:0]  parity_byte_lines_o,
  input wire logic [pss_pkg::LANES-1:0]  parity_byte_lines_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import pss_pkg::*;
  // ==========
  // decoded pin levels and properties
  logic sel, ps, cs, wr, drv;  // decoded pin levels
  assign sel = !primary_chip_select_n && high_chip_select
               && !third_chip_select_n;
  assign ps  = !processor_address_strobe_n;
  assign cs  = !controller_address_strobe_n;
  assign wr  = !all_lanes_write_n;
  assign drv = dq_oe != '0 || parity_byte_lines_oe != '0;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_desel;
    cs && primary_chip_select_n;
  endsequence
  sequence s_awake;
    (!sleep_request)[*4];
  endsequence
  sequence s_quiet;
    !cs && !(ps && !primary_chip_select_n);
  endsequence
  AST_OE_ENABLE: assert property (output_drive_enable_n |-> !drv)
    else $error("data lines driven while enable high");
  AST_OE_SAME: assert property (parity_byte_lines_oe == {LANES{dq_oe[0]}}
    && dq_oe == {DATA_W{dq_oe[0]}})
    else $error("drive enables differ between lines");
  AST_SLEEP: assert property (sleep_request [*4] |-> !drv)
    else $error("data lines driven while asleep");
  AST_READ_OE: assert property (s_awake ##0 (ps && sel)
    ##1 (!output_drive_enable_n && !sleep_request)[*2]
    |-> dq_oe == '1 && parity_byte_lines_oe == '1)
    else $error("read data not driven");
  AST_FIRST: assert property (s_desel ##1 (ps && sel) |=> !drv)
    else $error("drive not masked on first read clock");
  AST_IGNORE: assert property (s_desel ##1 s_quiet [*3] |-> !drv)
    else $error("ignored strobe started a read");
  AST_WRITE: assert property (s_desel ##1 (cs && !ps && sel && wr)
    ##1 (!cs && !ps && wr)[*2] |-> !drv)
    else $error("write burst drove the data lines");
  AST_DATA: assert property (s_awake ##0 (cs && !ps && sel && wr)
    ##1 (ps && sel && !sleep_request && addr == $past(addr))
    |-> ##2 (dq_o == $past(dq_i, 3)
    && parity_byte_lines_o == $past(parity_byte_lines_i, 3)))
    else $error("read after write returned other data");
endmodule // pss_sram_chk

// ==== tb/tb.sv ====
// bench: drives the sram core and mirrors it in a word model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pss_pkg::*;
  // ==========
  // pins, model state and counters
  logic mclk, rst_n, burst_advance_n, all_lanes_write_n, sleep_request;
  logic processor_address_strobe_n, controller_address_strobe_n;
  logic primary_chip_select_n, byte_write_gate_n, output_drive_enable_n;
  logic burst_order_strap, high_chip_select, third_chip_select_n;
  logic [ADDR_W-1:0] addr, base, bt;
  logic [DATA_W-1:0] dq_i, dq_o, dq_oe;
  logic [LANES-1:0]  lane_write_select_n, parity_byte_lines_i, ln;
  logic [LANES-1:0]  parity_byte_lines_o, parity_byte_lines_oe;
  logic [35:0]       hd, p1d, p2d, rd, oe, mem [logic [ADDR_W-1:0]];
  logic [1:0]        k;        // burst step of the model
  logic [4:0]        r;
  logic              hen, ilv, open, asleep, opn, p1, p2, quiet;
  int                error_cnt, checked, seed = 43409;
  assign rd = {parity_byte_lines_o, dq_o};
  assign oe = {parity_byte_lines_oe, dq_oe};
  pss_sram dut (.*);
  pss_host host (.mclk(mclk), .dev_d(rd), .dev_oe(oe), .host_d(hd),
    .host_en(hen), .line({parity_byte_lines_i, dq_i}));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input bit ok, input string m);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus edge: compare the answer due now, then drive and model
  task automatic drv(input logic p, c, e, v, g,
                     input logic [ADDR_W-1:0] ad);
    logic [ADDR_W-1:0] wa;
    @(negedge mclk);
    if (p2) check(rd === p2d, "read data");
    if (p2) check(oe === {36{!output_drive_enable_n}}, "drive");
    if (p1 && opn) check(oe === '0, "first read clock");
    p2 = p1;
    p2d = p1d;
    p1 = 0;
    {processor_address_strobe_n, controller_address_strobe_n} = {p, c};
    {primary_chip_select_n, burst_advance_n, all_lanes_write_n} = {e, v, g};
    addr = ad;
    {byte_write_gate_n, lane_write_select_n} = 5'($random(seed));
    hd = 36'({$random(seed), $random(seed)});
    ln = !g ? 4'hF : !byte_write_gate_n ? ~lane_write_select_n : 4'h0;
    hen = ln != 0;
    output_drive_enable_n = hen | quiet;  // host never fights the device
    opn = !open;
    if (asleep) open = 0;
    else if (!p && !e) begin
      {open, base, k, p1} = {1'b1, ad, 2'h0, 1'b1};
    end else if (!c) begin
      {open, base, k, p1} = {!e, ad, 2'h0, !e && !hen};
    end else if (open) begin
      {opn, p1} = {1'b0, !hen};
      k = k + 2'(!v);
    end
    wa = {base[17:2], ilv ? base[1:0] ^ k : base[1:0] + k};
    if (open && !p1 && hen) begin
      if (!mem.exists(wa)) mem[wa] = 'x;
      for (int i = 0; i < 4; i++) if (ln[i]) begin
        mem[wa][8*i+:8] = hd[8*i+:8];
        mem[wa][32+i] = hd[32+i];
      end
    end
    p1d = mem.exists(wa) ? mem[wa] : 'x;
  endtask
  initial begin
    {rst_n, sleep_request, quiet, hen, p1, p2, open, asleep} = '0;
    {processor_address_strobe_n, controller_address_strobe_n} = '1;
    {burst_advance_n, all_lanes_write_n, high_chip_select} = '1;
    {byte_write_gate_n, lane_write_select_n, burst_order_strap, ilv} = '1;
    {primary_chip_select_n, third_chip_select_n, output_drive_enable_n} = '0;
    {addr, hd, k, base, bt, opn} = '0;
    repeat (12) @(posedge mclk);
    @(negedge mclk) rst_n = 1;
    for (int m = 0; m < 2; m++) begin
      drv(1, 0, 1, 1, 1, '0);
      {burst_order_strap, ilv} = {2{m[0]}};
      repeat (3) drv(0, 1, 1, 1, 1, '1);
      bt = 18'($random(seed));
      drv(1, 0, 1, 1, 1, '0);
      drv(1, 0, 0, 1, 0, bt);
      repeat (3) drv(1, 1, 0, 0, 0, bt);
      drv(1, 0, 1, 1, 1, bt);
      drv(0, 1, 0, 1, 1, bt);
      repeat (3) drv(1, 1, 0, 0, 1, bt);
      drv(0, 1, 1, 0, 1, bt);
      drv(0, 0, 0, 1, 0, bt ^ 18'h1);
      drv(1, 0, 0, 1, 0, bt);
      drv(0, 1, 0, 1, 1, bt);
      quiet = 1;
      repeat (3) drv(0, 1, 0, 1, 1, bt);
      quiet = 0;
    end
    drv(1, 0, 1, 1, 1, '0);
    {sleep_request, asleep} = '1;
    repeat (4) drv(1, 1, 0, 1, 1, bt);
    repeat (3) drv(0, 1, 0, 1, 1, bt);
    check(oe === '0, "asleep");
    sleep_request = 0;
    repeat (4) drv(1, 1, 0, 1, 1, bt);
    asleep = 0;
    drv(0, 1, 0, 1, 1, bt);
    repeat (60) begin
      r = 5'($random(seed));
      drv(r[0], r[1], r[2] & r[3], r[3], r[4], {bt[17:2], r[3:2]});
    end
    repeat (3) drv(1, 1, 0, 1, 1, bt);
    end_of_test();
  end
  initial begin
    #40000;
    check(1'b0, "timeout");
    end_of_test();
  end
endmodule // tb
bind pss_sram pss_sram_chk chk (.*);
